//--- uart_status_pkg.sv
// constants, field layout and carriers for the uart status and interrupt block
// assumes an apb slave wrapper-free top, 32-bit data, one word per register
// Contract
// - fifo error summary is 0 in single mode, held while errored entries remain
// - transmitter idle only when shift register and holding register or fifo empty
// - holding empty sets on transfer or fifo empty, clears on host byte write
// - break flag sets on a silent character, follows top entry, cleared by status read
// - framing flag sets on missing stop bit, follows top entry, cleared by read
// - parity flag sets on bad parity, follows top entry, cleared by status read
// - overrun flag sets when an unread character is lost, cleared by status read
// - data ready while any received character waits, else 0
// - loopback holds serial output high, ignores serial input, idles modem pins
// - loopback feeds modem inputs from control bits 0,1,2,3
// - interrupt output enabled only by control bit 3; bit 2 used only in loopback
// - request and terminal ready pins are inverted control bits 1 and 0
// - modem status 7:4 are inverted pins, or control bits 3,2,0,1 in loopback
// - change bits record pin changes and ring trailing edge since last read
// - fifo control 7:6 select receive threshold 1, 4, 8 or 14 bytes
// - fifo control bit 3 selects dma mode 1 only while fifo is enabled
// - fifo control bits 2 and 1 reset transmit or receive fifo, self clearing
// - fifo control bit 0 enables fifo mode; software sets it first
// - identification 7:6 read 1 in fifo mode, 5:4 always 0
// - identification bit 0 is 1 when nothing pending; bit 3 0 in single mode
// - identification 3:1 gives highest pending source; its read clears tx empty
// - fifo timeout after four idle character times, cleared by buffer read
// - each source reported only when its enable bit is set; enable 7:4 read 0
package uart_status_pkg;
	// register indices, byte address is four times the index
	localparam logic [2:0] IDX_DATA = 3'h0;
	localparam logic [2:0] IDX_IRQ_ENABLE = 3'h1;
	localparam logic [2:0] IDX_IDENT_FIFO = 3'h2;
	localparam logic [2:0] IDX_MODEM_CONTROL = 3'h4;
	localparam logic [2:0] IDX_LINE_STATUS = 3'h5;
	localparam logic [2:0] IDX_MODEM_STATUS = 3'h6;
	// modem control fields
	localparam int MC_DTR = 0;
	localparam int MC_RTS = 1;
	localparam int MC_LOOP_RI = 2;
	localparam int MC_IRQ_EN = 3;
	localparam int MC_LOOP = 4;
	// fifo control fields
	localparam int FC_ENABLE = 0;
	localparam int FC_RX_RESET = 1;
	localparam int FC_TX_RESET = 2;
	localparam int FC_DMA = 3;
	// identification codes for bits 3:1
	localparam logic [2:0] ID_LINE = 3'h3;
	localparam logic [2:0] ID_DATA = 3'h2;
	localparam logic [2:0] ID_TIMEOUT = 3'h6;
	localparam logic [2:0] ID_TX = 3'h1;
	localparam logic [2:0] ID_MODEM = 3'h0;
	// receive thresholds in bytes
	localparam logic [4:0] THR_1 = 5'h01;
	localparam logic [4:0] THR_4 = 5'h04;
	localparam logic [4:0] THR_8 = 5'h08;
	localparam logic [4:0] THR_14 = 5'h0E;
	localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
	localparam logic [7:0] MODEM_CONTROL_RESET = 8'h00;
	localparam logic [7:0] FIFO_CONTROL_RESET = 8'h00;
	localparam logic [3:0] IRQ_ENABLE_RESET = 4'h0;
	// one received character with its error marks
	typedef struct packed {
		logic brk;
		logic framing;
		logic parity;
		logic [7:0] data;
	} rx_entry_t;
	// modem lines, active high
	typedef struct packed {
		logic dcd;
		logic ri;
		logic dsr;
		logic cts;
	} modem_lines_t;
endpackage : uart_status_pkg

//--- uart_status.sv
// status, modem handshake, fifo control and interrupt identification of a uart
// assumes the shifters and baud logic outside; char_tick pulses once per character time
`timescale 1ns/10ps
module uart_status #(
	parameter int RX_DEPTH = 16
) (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// modem pins, active low
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic dcd_n,
	output logic rts_n,
	output logic dtr_n,
	// serial pins and core serial paths
	input wire logic serial_in,
	input wire logic core_serial_out,
	output logic serial_out,
	output logic core_serial_in,
	// transmit side of the core
	input wire logic tx_load,
	input wire logic tx_shift_empty,
	input wire logic tx_fifo_empty,
	output logic tx_write,
	output logic [7:0] tx_data,
	output logic tx_fifo_reset,
	// receive side of the core
	input wire logic rx_valid,
	input wire uart_status_pkg::rx_entry_t rx_in,
	input wire logic char_tick,
	// mode and interrupt
	output logic fifo_enable,
	output logic dma_mode,
	output logic irq
);
	// depth must cover the top threshold and fit the four-bit pointers
	if (RX_DEPTH < 14 || RX_DEPTH > 16) begin : g_depth_check
		$error("RX_DEPTH must lie in 14..16");
	end

	// bus decode, action at the completing access edge
	logic done;
	logic wr;
	logic rd;
	logic [2:0] idx;
	logic mapped;
	assign done = psel & penable & pready;
	assign wr = done & pwrite & mapped;
	assign rd = done & ~pwrite & mapped;
	assign idx = paddr[4:2];
	assign mapped = (paddr[11:5] == 7'h00) &&
		(idx == uart_status_pkg::IDX_DATA || idx == uart_status_pkg::IDX_IRQ_ENABLE ||
		idx == uart_status_pkg::IDX_IDENT_FIFO || idx == uart_status_pkg::IDX_MODEM_CONTROL ||
		idx == uart_status_pkg::IDX_LINE_STATUS || idx == uart_status_pkg::IDX_MODEM_STATUS);

	logic rd_data;
	logic rd_ident;
	logic rd_line;
	logic rd_modem;
	assign rd_data = rd && idx == uart_status_pkg::IDX_DATA;
	assign rd_ident = rd && idx == uart_status_pkg::IDX_IDENT_FIFO;
	assign rd_line = rd && idx == uart_status_pkg::IDX_LINE_STATUS;
	assign rd_modem = rd && idx == uart_status_pkg::IDX_MODEM_STATUS;

	// control registers
	logic [3:0] irq_enable_reg;
	logic [7:0] modem_control_reg;
	logic [7:0] fifo_control_reg;
	logic fifo_on;
	assign fifo_on = fifo_control_reg[uart_status_pkg::FC_ENABLE];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable_reg <= uart_status_pkg::IRQ_ENABLE_RESET;
			modem_control_reg <= uart_status_pkg::MODEM_CONTROL_RESET;
			fifo_control_reg <= uart_status_pkg::FIFO_CONTROL_RESET;
		end else if (wr) begin
			if (idx == uart_status_pkg::IDX_IRQ_ENABLE)
				irq_enable_reg <= pwdata[3:0];
			if (idx == uart_status_pkg::IDX_MODEM_CONTROL)
				modem_control_reg <= {3'h0, pwdata[4:0]};
			if (idx == uart_status_pkg::IDX_IDENT_FIFO)
				fifo_control_reg <= {pwdata[7:6], 2'h0, pwdata[3], 2'h0, pwdata[0]};
		end
	end

	// fifo resets: explicit bits, or a change of fifo mode
	logic fc_write;
	logic rx_reset;
	logic tx_reset;
	assign fc_write = wr && idx == uart_status_pkg::IDX_IDENT_FIFO;
	assign rx_reset = fc_write & (pwdata[uart_status_pkg::FC_RX_RESET] | (pwdata[0] ^ fifo_on));
	assign tx_reset = fc_write & (pwdata[uart_status_pkg::FC_TX_RESET] | (pwdata[0] ^ fifo_on));

	// receive threshold decode
	logic [4:0] threshold;
	always_comb begin
		unique case (fifo_control_reg[7:6])
			2'b00: threshold = uart_status_pkg::THR_1;
			2'b01: threshold = uart_status_pkg::THR_4;
			2'b10: threshold = uart_status_pkg::THR_8;
			2'b11: threshold = uart_status_pkg::THR_14;
		endcase
	end

	// receive fifo, depth one in single mode
	uart_status_pkg::rx_entry_t rx_mem [RX_DEPTH];
	logic [3:0] rd_ptr_reg;
	logic [3:0] wr_ptr_reg;
	logic [4:0] count_reg;
	logic [4:0] err_cnt_reg;
	logic [4:0] capacity;
	logic full;
	logic pop;
	logic push;
	logic overwrite;
	uart_status_pkg::rx_entry_t top;
	assign capacity = fifo_on ? 5'(RX_DEPTH) : 5'h01;
	assign full = count_reg >= capacity;
	assign pop = rd_data && count_reg != 5'h00;
	assign push = rx_valid && !full;
	assign overwrite = rx_valid && full && !fifo_on && !pop;
	assign top = rx_mem[rd_ptr_reg];

	function automatic logic has_err(input uart_status_pkg::rx_entry_t e);
		has_err = e.brk | e.framing | e.parity;
	endfunction : has_err

	function automatic logic [3:0] ptr_inc(input logic [3:0] p);
		ptr_inc = (p == 4'(RX_DEPTH - 1)) ? 4'h0 : p + 4'h1;
	endfunction : ptr_inc

	// storage array
	always_ff @(posedge pclk) begin
		if (push)
			rx_mem[wr_ptr_reg] <= rx_in;
		else if (overwrite)
			rx_mem[rd_ptr_reg] <= rx_in;
	end

	// pointers, count and error entry count
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_ptr_reg <= 4'h0;
			wr_ptr_reg <= 4'h0;
			count_reg <= 5'h00;
			err_cnt_reg <= 5'h00;
		end else if (rx_reset) begin
			rd_ptr_reg <= 4'h0;
			wr_ptr_reg <= 4'h0;
			count_reg <= 5'h00;
			err_cnt_reg <= 5'h00;
		end else begin
			if (push)
				wr_ptr_reg <= ptr_inc(wr_ptr_reg);
			if (pop)
				rd_ptr_reg <= ptr_inc(rd_ptr_reg);
			count_reg <= count_reg + 5'(push) - 5'(pop);
			err_cnt_reg <= err_cnt_reg + 5'(push & has_err(rx_in)) - 5'(pop & has_err(top));
		end
	end

	// marks that a new entry reached the top of the fifo
	logic top_new_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			top_new_reg <= 1'b0;
		else
			top_new_reg <= !rx_reset && ((push && count_reg == 5'h00) ||
				(pop && count_reg > 5'h01) || overwrite);
	end

	// line status flags, an arriving event wins over the read clear
	logic parity_error;
	logic framing_error;
	logic break_detected;
	logic overrun_error;
	logic fifo_error_pending;
	logic tx_holding_empty;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			parity_error <= 1'b0;
			framing_error <= 1'b0;
			break_detected <= 1'b0;
			overrun_error <= 1'b0;
			fifo_error_pending <= 1'b0;
		end else begin
			parity_error <= (top_new_reg & top.parity) | (parity_error & ~rd_line);
			framing_error <= (top_new_reg & top.framing) | (framing_error & ~rd_line);
			break_detected <= (top_new_reg & top.brk) | (break_detected & ~rd_line);
			overrun_error <= (rx_valid & full) | (overrun_error & ~rd_line);
			fifo_error_pending <= fifo_on & ((err_cnt_reg != 5'h00) |
				(fifo_error_pending & ~rd_line));
		end
	end

	// holding empty flag and its interrupt source
	logic tx_byte_wr;
	logic tx_fifo_empty_d;
	logic tx_empty_set;
	logic tx_irq_reg;
	logic iid_is_tx;
	assign tx_byte_wr = wr && idx == uart_status_pkg::IDX_DATA;
	assign tx_empty_set = fifo_on ? (tx_fifo_empty & ~tx_fifo_empty_d) : tx_load;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_holding_empty <= 1'b1;
			tx_irq_reg <= 1'b0;
			tx_fifo_empty_d <= 1'b1;
		end else begin
			tx_fifo_empty_d <= tx_fifo_empty;
			tx_holding_empty <= tx_empty_set | (tx_holding_empty & ~tx_byte_wr);
			tx_irq_reg <= tx_empty_set | (tx_irq_reg & ~tx_byte_wr & ~(rd_ident & iid_is_tx));
		end
	end

	// transmitter idle flag
	logic transmitter_idle;
	assign transmitter_idle = tx_shift_empty & (fifo_on ? tx_fifo_empty : tx_holding_empty);

	// receive timeout: four character times with data and no fifo access
	logic [2:0] idle_chars_reg;
	logic timeout_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_chars_reg <= 3'h0;
			timeout_reg <= 1'b0;
		end else if (!fifo_on || count_reg == 5'h00 || push || rd_data || rx_reset) begin
			idle_chars_reg <= 3'h0;
			timeout_reg <= 1'b0;
		end else if (char_tick && idle_chars_reg < uart_status_pkg::TIMEOUT_CHARS) begin
			idle_chars_reg <= idle_chars_reg + 3'h1;
			timeout_reg <= idle_chars_reg == uart_status_pkg::TIMEOUT_CHARS - 3'h1;
		end
	end

	// effective modem inputs, from pins or loopback control bits
	logic loop;
	uart_status_pkg::modem_lines_t lines;
	uart_status_pkg::modem_lines_t lines_prev_reg;
	logic [3:0] changed_reg;
	assign loop = modem_control_reg[uart_status_pkg::MC_LOOP];
	always_comb begin
		if (loop) begin
			lines.dcd = modem_control_reg[uart_status_pkg::MC_IRQ_EN];
			lines.ri = modem_control_reg[uart_status_pkg::MC_LOOP_RI];
			lines.dsr = modem_control_reg[uart_status_pkg::MC_DTR];
			lines.cts = modem_control_reg[uart_status_pkg::MC_RTS];
		end else begin
			lines = ~{dcd_n, ri_n, dsr_n, cts_n};
		end
	end

	// change detection, bits 3..0 are carrier, ring trailing edge, dsr, cts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lines_prev_reg <= 4'h0;
			changed_reg <= 4'h0;
		end else begin
			lines_prev_reg <= lines;
			changed_reg[3] <= (lines.dcd ^ lines_prev_reg.dcd) | (changed_reg[3] & ~rd_modem);
			changed_reg[2] <= (lines_prev_reg.ri & ~lines.ri) | (changed_reg[2] & ~rd_modem);
			changed_reg[1] <= (lines.dsr ^ lines_prev_reg.dsr) | (changed_reg[1] & ~rd_modem);
			changed_reg[0] <= (lines.cts ^ lines_prev_reg.cts) | (changed_reg[0] & ~rd_modem);
		end
	end

	// interrupt sources and priority
	logic src_line;
	logic src_data;
	logic src_timeout;
	logic src_tx;
	logic src_modem;
	logic [2:0] iid;
	logic pending;
	assign src_line = irq_enable_reg[2] & (overrun_error | parity_error | framing_error | break_detected);
	assign src_data = irq_enable_reg[0] & (fifo_on ? count_reg >= threshold : count_reg != 5'h00);
	assign src_timeout = irq_enable_reg[0] & timeout_reg;
	assign src_tx = irq_enable_reg[1] & tx_irq_reg;
	assign src_modem = irq_enable_reg[3] & (changed_reg != 4'h0);
	assign pending = src_line | src_data | src_timeout | src_tx | src_modem;
	assign iid_is_tx = iid == uart_status_pkg::ID_TX && pending;
	always_comb begin
		if (src_line)
			iid = uart_status_pkg::ID_LINE;
		else if (src_data)
			iid = uart_status_pkg::ID_DATA;
		else if (src_timeout)
			iid = uart_status_pkg::ID_TIMEOUT;
		else if (src_tx)
			iid = uart_status_pkg::ID_TX;
		else
			iid = uart_status_pkg::ID_MODEM;
	end

	// read mux
	logic [7:0] read_byte;
	always_comb begin
		read_byte = 8'h00;
		unique case (idx)
			uart_status_pkg::IDX_DATA: read_byte = top.data;
			uart_status_pkg::IDX_IRQ_ENABLE: read_byte = {4'h0, irq_enable_reg};
			uart_status_pkg::IDX_IDENT_FIFO: read_byte = {{2{fifo_on}}, 2'h0,
				pending ? iid : 3'h0, ~pending};
			uart_status_pkg::IDX_MODEM_CONTROL: read_byte = modem_control_reg;
			uart_status_pkg::IDX_LINE_STATUS: read_byte = {fifo_error_pending, transmitter_idle,
				tx_holding_empty, break_detected, framing_error, parity_error, overrun_error,
				count_reg != 5'h00};
			uart_status_pkg::IDX_MODEM_STATUS: read_byte = {lines, changed_reg};
			default: read_byte = 8'h00;
		endcase
	end

	// apb answer: one wait cycle, then ready with data or error
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= psel & penable & ~pready;
			pslverr <= psel & penable & ~pready & ~mapped;
			if (psel & penable & ~pready & ~pwrite & mapped)
				prdata <= {24'h000000, read_byte};
			else if (done)
				prdata <= 32'h00000000;
		end
	end

	// pins and core strobes, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rts_n <= 1'b1;
			dtr_n <= 1'b1;
			serial_out <= 1'b1;
			core_serial_in <= 1'b1;
			tx_write <= 1'b0;
			tx_data <= 8'h00;
			tx_fifo_reset <= 1'b0;
			fifo_enable <= 1'b0;
			dma_mode <= 1'b0;
			irq <= 1'b0;
		end else begin
			rts_n <= loop | ~modem_control_reg[uart_status_pkg::MC_RTS];
			dtr_n <= loop | ~modem_control_reg[uart_status_pkg::MC_DTR];
			serial_out <= loop | core_serial_out;
			core_serial_in <= loop ? core_serial_out : serial_in;
			tx_write <= tx_byte_wr;
			if (tx_byte_wr)
				tx_data <= pwdata[7:0];
			tx_fifo_reset <= tx_reset;
			fifo_enable <= fifo_on;
			dma_mode <= fifo_on & fifo_control_reg[uart_status_pkg::FC_DMA];
			irq <= modem_control_reg[uart_status_pkg::MC_IRQ_EN] & pending;
		end
	end
endmodule : uart_status

//--- uart_status_properties.sv
// port assertions for the uart status and interrupt block
// assumes pclk rising edge sampling and presetn asynchronous active low
`timescale 1ns/10ps
module uart_status_checker (
	// apb
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// pins and modes
	input wire logic rts_n,
	input wire logic dtr_n,
	input wire logic serial_in,
	input wire logic core_serial_out,
	input wire logic serial_out,
	input wire logic core_serial_in,
	input wire logic tx_fifo_reset,
	input wire logic fifo_enable,
	input wire logic dma_mode,
	input wire logic irq
);
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	logic wr_mc;
	logic wr_fc;
	logic live_reg;
	logic [4:0] mc_reg;
	// completed writes to modem control and fifo control
	assign wr_mc = psel && penable && pready && pwrite && paddr == 12'h010;
	assign wr_fc = psel && penable && pready && pwrite && paddr == 12'h008;
	// shadow of modem control; live skips the first edge after reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			live_reg <= 1'b0;
			mc_reg <= 5'h00;
		end else begin
			live_reg <= 1'b1;
			if (wr_mc) begin
				mc_reg <= pwdata[4:0];
			end
		end
	end
	property p_ready_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("pready late");
	property p_ready_once;
		pready |=> !pready;
	endproperty
	a_ready_once: assert property (p_ready_once) else $error("pready held");
	property p_idle_bus;
		!pready |-> !pslverr && prdata == 32'h00000000;
	endproperty
	a_idle_bus: assert property (p_idle_bus) else $error("read bus not idle");
	property p_pins;
		live_reg && !$past(mc_reg[4]) |-> rts_n == !$past(mc_reg[1]) && dtr_n == !$past(mc_reg[0]);
	endproperty
	a_pins: assert property (p_pins) else $error("handshake pins wrong");
	property p_loop_out;
		live_reg && $past(mc_reg[4]) |-> serial_out && rts_n && dtr_n;
	endproperty
	a_loop_out: assert property (p_loop_out) else $error("loopback outputs not idle");
	property p_ser_out;
		live_reg && !$past(mc_reg[4]) |-> serial_out == $past(core_serial_out);
	endproperty
	a_ser_out: assert property (p_ser_out) else $error("serial output wrong");
	property p_ser_in;
		live_reg |-> core_serial_in == ($past(mc_reg[4]) ? $past(core_serial_out) : $past(serial_in));
	endproperty
	a_ser_in: assert property (p_ser_in) else $error("receiver input wrong");
	property p_irq_gate;
		live_reg && !$past(mc_reg[3]) |-> !irq;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq not gated");
	property p_dma;
		dma_mode |-> fifo_enable;
	endproperty
	a_dma: assert property (p_dma) else $error("dma mode without fifo");
	property p_txr_pulse;
		tx_fifo_reset |=> !tx_fifo_reset;
	endproperty
	a_txr_pulse: assert property (p_txr_pulse) else $error("fifo reset not self clearing");
	property p_fen_cause;
		live_reg && $changed(fifo_enable) |-> $past(wr_fc) || $past(wr_fc, 2);
	endproperty
	a_fen_cause: assert property (p_fen_cause) else $error("fifo mode changed alone");
	// main scenarios
	c_loop: cover property (wr_mc && pwdata[4]);
	c_irq: cover property ($rose(irq));
	c_fifo: cover property ($rose(fifo_enable));
	c_err: cover property (pslverr);
endmodule : uart_status_checker

//--- modem_peer.sv
// modem peer driving the active low handshake lines
// assumes the bench sets the wanted line states; lines move just after an edge
`timescale 1ns/10ps
module modem_peer (
	// clock and wanted states
	input wire logic pclk,
	input wire uart_status_pkg::modem_lines_t want,
	// lines toward the block
	output logic cts_n,
	output logic dsr_n,
	output logic ri_n,
	output logic dcd_n
);
	logic [3:0] lines_n = 4'hF;
	// lines are registered so they never change on the sampling edge
	always @(posedge pclk) begin
		lines_n <= ~want;
	end
	assign {dcd_n, ri_n, dsr_n, cts_n} = lines_n;
endmodule : modem_peer

//--- testbench.sv
// self-checking bench for the uart status block over apb
// assumes the package, the design, the checker and the modem peer compiled first
`timescale 1ns/10ps
bind uart_status uart_status_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
	.prdata, .pready, .pslverr, .rts_n, .dtr_n, .serial_in, .core_serial_out, .serial_out, .core_serial_in,
	.tx_fifo_reset, .fifo_enable, .dma_mode, .irq);
module testbench;
	localparam logic [2:0] A_DAT = uart_status_pkg::IDX_DATA;
	localparam logic [2:0] A_IEN = uart_status_pkg::IDX_IRQ_ENABLE;
	localparam logic [2:0] A_ID = uart_status_pkg::IDX_IDENT_FIFO;
	localparam logic [2:0] A_MC = uart_status_pkg::IDX_MODEM_CONTROL;
	localparam logic [2:0] A_LS = uart_status_pkg::IDX_LINE_STATUS;
	localparam logic [2:0] A_MS = uart_status_pkg::IDX_MODEM_STATUS;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic cts_n, dsr_n, ri_n, dcd_n, rts_n, dtr_n, serial_in, core_serial_out, serial_out, core_serial_in;
	logic tx_load, tx_shift_empty, tx_fifo_empty, tx_write, tx_fifo_reset, rx_valid, char_tick;
	logic fifo_enable, dma_mode, irq;
	logic [7:0] tx_data, q, tx_last;
	uart_status_pkg::rx_entry_t rx_in;
	uart_status_pkg::modem_lines_t want;
	int err_total = 0, cmp_count = 0, tx_seen = 0, txr_seen = 0;
	int thr[4] = '{1, 4, 8, 14};
	uart_status #(.RX_DEPTH(16)) u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .cts_n, .dsr_n, .ri_n, .dcd_n, .rts_n, .dtr_n, .serial_in, .core_serial_out,
		.serial_out, .core_serial_in, .tx_load, .tx_shift_empty, .tx_fifo_empty, .tx_write, .tx_data,
		.tx_fifo_reset, .rx_valid, .rx_in, .char_tick, .fifo_enable, .dma_mode, .irq);
	modem_peer u_peer (.pclk, .want, .cts_n, .dsr_n, .ri_n, .dcd_n);
	// 40 MHz clock
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end
	// counts transmit byte pulses and transmit fifo reset pulses
	always @(posedge pclk) begin
		if (tx_write === 1'b1) begin
			tx_seen++;
			tx_last = tx_data;
		end
		if (tx_fifo_reset === 1'b1) txr_seen++;
	end
	task automatic give_verdict();
		$display("compares %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	task automatic chk(input string s, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", s, exp, seen);
		end
	endtask : chk
	// one apb transfer; setup, then access until pready
	task automatic apb(input logic w, input logic [2:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, 7'h00, i, 2'h0, 24'h000000, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) err_total++;
		q = prdata[7:0];
		e = pslverr;
		{psel, penable} <= 2'h0;
	endtask : apb
	task automatic wr(input logic [2:0] i, input logic [7:0] d);
		apb(1'b1, i, d);
	endtask : wr
	task automatic rc(input string s, input logic [2:0] i, input logic [7:0] x);
		apb(1'b0, i, 8'h00);
		chk(s, q, x);
	endtask : rc
	task automatic push(input uart_status_pkg::rx_entry_t v);
		@(posedge pclk);
		{rx_valid, rx_in} <= {1'b1, v};
		@(posedge pclk);
		rx_valid <= 1'b0;
	endtask : push
	// cuts a hang short
	initial begin
		#200000;
		err_total++;
		give_verdict();
	end
	// main sequence
	initial begin
		{presetn, psel, penable, pwrite, rx_valid, char_tick, tx_load} = 7'h00;
		{serial_in, core_serial_out, tx_shift_empty, tx_fifo_empty} = 4'hF;
		{paddr, pwdata, rx_in, want} = '0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		rc("line status", A_LS, 8'h60);
		rc("ident", A_ID, 8'h01);
		rc("modem status", A_MS, 8'h00);
		apb(1'b0, 3'h3, 8'h00);
		chk("unmapped", {e, q[6:0]}, 8'h80);
		// handshake outputs and diagnostic loopback
		wr(A_MC, 8'h03);
		core_serial_out <= 1'b0;
		repeat (2) @(posedge pclk);
		chk("rts dtr", {6'h00, rts_n, dtr_n}, 8'h00);
		wr(A_MC, 8'h15);
		repeat (2) @(posedge pclk);
		chk("loop pins", {4'h0, serial_out, core_serial_in, rts_n, dtr_n}, 8'h0B);
		rc("loop status", A_MS, 8'h62);
		rc("loop again", A_MS, 8'h60);
		wr(A_MC, 8'hFA);
		rc("control read", A_MC, 8'h1A);
		rc("loop swap", A_MS, 8'h9F);
		wr(A_MC, 8'h08);
		rc("back to pins", A_MS, 8'h09);
		chk("line pins", {6'h00, serial_out, core_serial_in}, 8'h01);
		// modem status interrupt, gated and masked
		wr(A_IEN, 8'h08);
		want.cts <= 1'b1;
		for (int i = 0; i < 8 && irq !== 1'b1; i++) @(posedge pclk);
		chk("modem irq", {7'h00, irq}, 8'h01);
		rc("modem ident", A_ID, 8'h00);
		rc("modem cts", A_MS, 8'h11);
		repeat (2) @(posedge pclk);
		chk("irq cleared", {7'h00, irq}, 8'h00);
		wr(A_MC, 8'h00);
		want.cts <= 1'b0;
		repeat (6) @(posedge pclk);
		chk("gated irq", {7'h00, irq}, 8'h00);
		rc("gated ident", A_ID, 8'h00);
		wr(A_IEN, 8'h00);
		rc("masked ident", A_ID, 8'h01);
		rc("cts change", A_MS, 8'h01);
		// single buffer receive and line errors
		wr(A_IEN, 8'hF5);
		rc("enable read", A_IEN, 8'h05);
		push(11'h1A5);
		rc("line ident", A_ID, 8'h06);
		rc("parity", A_LS, 8'h65);
		rc("data ident", A_ID, 8'h04);
		rc("rx data", A_DAT, 8'hA5);
		rc("rx empty", A_LS, 8'h60);
		push(11'h011);
		push(11'h022);
		rc("overrun", A_LS, 8'h63);
		rc("overwritten", A_DAT, 8'h22);
		push(11'h600);
		rc("break framing", A_LS, 8'h79);
		rc("break data", A_DAT, 8'h00);
		// transmit holding register and shifter
		wr(A_IEN, 8'h00);
		tx_shift_empty <= 1'b0;
		wr(A_DAT, 8'h5A);
		repeat (2) @(posedge pclk);
		chk("tx byte", tx_last, 8'h5A);
		chk("tx pulses", tx_seen[7:0], 8'h01);
		rc("tx full", A_LS, 8'h00);
		@(posedge pclk);
		tx_load <= 1'b1;
		@(posedge pclk);
		tx_load <= 1'b0;
		rc("tx moved", A_LS, 8'h20);
		tx_shift_empty <= 1'b1;
		rc("tx idle", A_LS, 8'h60);
		wr(A_IEN, 8'h02);
		rc("tx ident", A_ID, 8'h02);
		rc("tx ident read", A_ID, 8'h01);
		// fifo mode, every threshold, timeout
		wr(A_ID, 8'h01);
		rc("fifo ident", A_ID, 8'hC1);
		wr(A_IEN, 8'h01);
		for (int k = 0; k < 4; k++) begin
			wr(A_ID, {k[1:0], 6'h03});
			for (int j = 1; j < thr[k]; j++) push({3'h0, j[7:0]});
			rc("below level", A_ID, 8'hC1);
			push(11'h0EE);
			rc("at level", A_ID, 8'hC4);
		end
		rc("fifo order", A_DAT, 8'h01);
		rc("under level", A_ID, 8'hC1);
		repeat (4) begin
			@(posedge pclk);
			char_tick <= 1'b1;
			@(posedge pclk);
			char_tick <= 1'b0;
		end
		repeat (2) @(posedge pclk);
		rc("timeout ident", A_ID, 8'hCC);
		rc("timeout pop", A_DAT, 8'h02);
		rc("timeout cleared", A_ID, 8'hC1);
		// transmit fifo busy, then drained, in fifo mode
		wr(A_DAT, 8'h3C);
		tx_fifo_empty <= 1'b0;
		rc("tx fifo busy", A_LS, 8'h01);
		tx_fifo_empty <= 1'b1;
		rc("tx fifo drained", A_LS, 8'h61);
		// fifo error summary
		wr(A_ID, 8'h03);
		push(11'h033);
		push(11'h144);
		rc("error summary", A_LS, 8'hE1);
		rc("summary held", A_LS, 8'hE1);
		rc("clean top", A_DAT, 8'h33);
		rc("errored top", A_LS, 8'hE5);
		// transmit fifo reset, dma mode, back to single mode
		txr_seen = 0;
		wr(A_ID, 8'h05);
		repeat (2) @(posedge pclk);
		chk("tx fifo reset", txr_seen[7:0], 8'h01);
		wr(A_ID, 8'h09);
		repeat (2) @(posedge pclk);
		chk("dma mode", {6'h00, dma_mode, fifo_enable}, 8'h03);
		wr(A_ID, 8'h08);
		repeat (2) @(posedge pclk);
		chk("dma needs fifo", {6'h00, dma_mode, fifo_enable}, 8'h00);
		rc("single ident", A_ID, 8'h01);
		rc("single status", A_LS, 8'h60);
		give_verdict();
	end
endmodule : testbench
